// File: shared/olma_defs.svh
// Constants for the output macrocell array: sizes, register map, field positions and reset values.
`ifndef OLMA_DEFS_SVH
`define OLMA_DEFS_SVH
`define OLMA_CELLS 8
`define OLMA_TERMS 8
`define OLMA_SIGS 16
`define OLMA_LITS 32
`define OLMA_DED_INS 6
`define OLMA_ADDR_W 10
`define OLMA_DATA_W 32
`define OLMA_OFS_CTRL 10'h000
`define OLMA_OFS_CELL 10'h004
`define OLMA_OFS_STAT 10'h008
`define OLMA_PT_REGION 2'h1
`define OLMA_REGION_MSB 9
`define OLMA_REGION_LSB 8
`define OLMA_PT_CELL_MSB 7
`define OLMA_PT_CELL_LSB 5
`define OLMA_PT_TERM_MSB 4
`define OLMA_PT_TERM_LSB 2
`define OLMA_CTRL_SYN_BIT 0
`define OLMA_CTRL_ARCH_BIT 1
`define OLMA_CELL_POL_LSB 0
`define OLMA_CELL_CFG_LSB 8
`define OLMA_CODE_SIMPLE 2'h1
`define OLMA_CODE_COMPLEX 2'h3
`define OLMA_CODE_REGISTERED 2'h2
`define OLMA_CTRL_RESET 2'h1
`define OLMA_CELL_RESET 8'h00
`define OLMA_PT_RESET 32'hFFFFFFFF
`define OLMA_OE_TERM 0
`define OLMA_OUTER_LO 0
`define OLMA_OUTER_HI 7
`define OLMA_INNER_LO 3
`define OLMA_INNER_HI 4
`define OLMA_FB_BASE 8
`define OLMA_DED_BASE 2
`define OLMA_SP_CLK 0
`define OLMA_SP_OE 1
`endif

// File: shared/olma_pkg.sv
// Types shared by the output macrocell array and its bench.
package olma_pkg;
  `include "olma_defs.svh"

  typedef enum logic [1:0] {OLMA_SIMPLE, OLMA_COMPLEX, OLMA_REGISTERED} olma_mode_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [`OLMA_ADDR_W-1:0] address;
    logic [`OLMA_DATA_W-1:0] writedata;
  } olma_bus_req_t;

  typedef struct packed {
    logic [1:0] special;
    logic [`OLMA_DED_INS-1:0] ded;
    logic [`OLMA_CELLS-1:0] io;
  } olma_pins_t;
endpackage

// File: rtl/olma_top.sv
// Eight configurable output macrocells with an Avalon-MM configuration port.
// Operation
// - Three modes, one applies to all cells.
// - Two global bits select the mode.
// - Per-cell polarity bit in every mode.
// - Per-cell bit picks input/output use.
// - Two global plus sixteen per-cell bits.
// - Registered: special pins are clock, enable.
// - Complex: special pins ride outer feedback paths.
// - Simple: inner two cells, output, no feedback.
// - Registered cells share clock and enable pins.
// - Registered: each cell register or I/O.
// - Registered sum eight terms, I/O seven.
// - Plain input or output as I/O subset.
// - Complex: output-only or I/O, six I/Os.
// - Complex: outer cells are outputs only.
// - Complex: seven sum terms, one enable term.
// - Complex: special pins feed array as data.
// - Registered: only register or I/O roles.
// - Simple: input or always-on eight-term output.
`include "olma_defs.svh"
module olma_top #(
  parameter logic [1:0] SIMPLE_CODE = `OLMA_CODE_SIMPLE,
  parameter logic [1:0] COMPLEX_CODE = `OLMA_CODE_COMPLEX,
  parameter logic [1:0] REGISTERED_CODE = `OLMA_CODE_REGISTERED
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire olma_pkg::olma_bus_req_t avs_req_in,
  output logic [`OLMA_DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire olma_pkg::olma_pins_t pins_in,
  output logic [`OLMA_CELLS-1:0] io_data_out,
  output logic [`OLMA_CELLS-1:0] io_oe_n_out
);
  import olma_pkg::*;

  olma_pins_t pin_meta;
  olma_pins_t pin_sync;
  logic clk_pin_last;
  logic clk_rise;
  logic [1:0] ctrl_bits;
  logic [`OLMA_CELLS-1:0] cell_pol;
  logic [`OLMA_CELLS-1:0] cell_io_cfg;
  logic [`OLMA_DATA_W-1:0] pt_mem [0:`OLMA_CELLS-1][0:`OLMA_TERMS-1];
  logic [1:0] mode_code;
  olma_mode_t mode;
  logic [`OLMA_SIGS-1:0] sig;
  logic [`OLMA_LITS-1:0] lits;
  logic [`OLMA_TERMS-1:0] term [0:`OLMA_CELLS-1];
  logic [`OLMA_CELLS-1:0] sum_all;
  logic [`OLMA_CELLS-1:0] sum_rest;
  logic [`OLMA_CELLS-1:0] oe_term;
  logic [`OLMA_CELLS-1:0] reg_q;
  logic [`OLMA_CELLS-1:0] next_io_data;
  logic [`OLMA_CELLS-1:0] next_io_oe_n;
  logic [`OLMA_DATA_W-1:0] next_readdata;
  logic bus_req;
  logic wr_take;
  logic pt_hit;

  // Pins are asynchronous to sys_clk_in, so everything passes two flops first.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
      clk_pin_last <= 1'b0;
    end else begin
      pin_meta <= pins_in;
      pin_sync <= pin_meta;
      clk_pin_last <= pin_sync.special[`OLMA_SP_CLK];
    end
  end

  assign clk_rise = pin_sync.special[`OLMA_SP_CLK] & ~clk_pin_last;

  assign mode_code = {ctrl_bits[`OLMA_CTRL_ARCH_BIT], ctrl_bits[`OLMA_CTRL_SYN_BIT]};

  always_comb begin
    if (mode_code == REGISTERED_CODE) begin
      mode = OLMA_REGISTERED;
    end else if (mode_code == COMPLEX_CODE) begin
      mode = OLMA_COMPLEX;
    end else begin
      mode = OLMA_SIMPLE;
    end
  end

  always_comb begin
    sig = '0;
    sig[`OLMA_DED_BASE +: `OLMA_DED_INS] = pin_sync.ded;
    unique case (mode)
      OLMA_SIMPLE: begin
        sig[1:0] = pin_sync.special;
        for (int i = 0; i < `OLMA_CELLS; i++) begin
          if (cell_io_cfg[i] && i != `OLMA_INNER_LO && i != `OLMA_INNER_HI) begin
            sig[`OLMA_FB_BASE + i] = pin_sync.io[i];
          end
        end
      end
      OLMA_COMPLEX: begin
        for (int i = 0; i < `OLMA_CELLS; i++) begin
          if (cell_io_cfg[i] && i != `OLMA_OUTER_LO && i != `OLMA_OUTER_HI) begin
            sig[`OLMA_FB_BASE + i] = pin_sync.io[i];
          end
        end
        sig[`OLMA_FB_BASE + `OLMA_OUTER_LO] = pin_sync.special[`OLMA_SP_CLK];
        sig[`OLMA_FB_BASE + `OLMA_OUTER_HI] = pin_sync.special[`OLMA_SP_OE];
      end
      OLMA_REGISTERED: begin
        for (int i = 0; i < `OLMA_CELLS; i++) begin
          sig[`OLMA_FB_BASE + i] = cell_io_cfg[i] ? pin_sync.io[i] : reg_q[i];
        end
      end
    endcase
  end

  // A term uses every literal whose mask bit is set; reset sets both polarities, so terms start false.
  always_comb begin
    for (int k = 0; k < `OLMA_SIGS; k++) begin
      lits[2*k] = sig[k];
      lits[2*k+1] = ~sig[k];
    end
    for (int c = 0; c < `OLMA_CELLS; c++) begin
      for (int t = 0; t < `OLMA_TERMS; t++) begin
        term[c][t] = &(lits | ~pt_mem[c][t]);
      end
    end
  end

  always_comb begin
    for (int c = 0; c < `OLMA_CELLS; c++) begin
      sum_all[c] = |term[c];
      sum_rest[c] = |(term[c] & ~(`OLMA_TERMS'(1) << `OLMA_OE_TERM));
      oe_term[c] = term[c][`OLMA_OE_TERM];
    end
  end

  always_comb begin
    next_io_data = '0;
    next_io_oe_n = '1;
    for (int c = 0; c < `OLMA_CELLS; c++) begin
      unique case (mode)
        OLMA_SIMPLE: begin
          if (!(cell_io_cfg[c] && c != `OLMA_INNER_LO && c != `OLMA_INNER_HI)) begin
            next_io_data[c] = sum_all[c] ^ cell_pol[c];
            next_io_oe_n[c] = 1'b0;
          end
        end
        OLMA_COMPLEX: begin
          next_io_data[c] = sum_rest[c] ^ cell_pol[c];
          next_io_oe_n[c] = ~oe_term[c];
        end
        OLMA_REGISTERED: begin
          if (!cell_io_cfg[c]) begin
            next_io_data[c] = reg_q[c] ^ cell_pol[c];
            next_io_oe_n[c] = pin_sync.special[`OLMA_SP_OE];
          end else begin
            next_io_data[c] = sum_rest[c] ^ cell_pol[c];
            next_io_oe_n[c] = ~oe_term[c];
          end
        end
      endcase
    end
  end

  // Pins stay released during reset so the board is not fought.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      io_data_out <= '0;
      io_oe_n_out <= '1;
    end else begin
      io_data_out <= next_io_data;
      io_oe_n_out <= next_io_oe_n;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_q <= '0;
    end else if (mode == OLMA_REGISTERED && clk_rise) begin
      reg_q <= (sum_all & ~cell_io_cfg) | (reg_q & cell_io_cfg);
    end
  end

  // One wait state per access keeps read data a registered output.
  assign bus_req = avs_req_in.read | avs_req_in.write;
  assign wr_take = avs_req_in.write & ~avs_waitrequest_out;
  assign pt_hit = avs_req_in.address[`OLMA_REGION_MSB:`OLMA_REGION_LSB] == `OLMA_PT_REGION;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
    end
  end

  always_comb begin
    next_readdata = '0;
    if (pt_hit) begin
      next_readdata = pt_mem[avs_req_in.address[`OLMA_PT_CELL_MSB:`OLMA_PT_CELL_LSB]]
                            [avs_req_in.address[`OLMA_PT_TERM_MSB:`OLMA_PT_TERM_LSB]];
    end else if (avs_req_in.address == `OLMA_OFS_CTRL) begin
      next_readdata = `OLMA_DATA_W'(ctrl_bits);
    end else if (avs_req_in.address == `OLMA_OFS_CELL) begin
      next_readdata = `OLMA_DATA_W'({cell_io_cfg, cell_pol});
    end else if (avs_req_in.address == `OLMA_OFS_STAT) begin
      next_readdata = `OLMA_DATA_W'({mode_code, io_data_out, reg_q});
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= '0;
    end else if (avs_req_in.read && avs_waitrequest_out) begin
      avs_readdata_out <= next_readdata;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_bits <= `OLMA_CTRL_RESET;
      cell_pol <= `OLMA_CELL_RESET;
      cell_io_cfg <= `OLMA_CELL_RESET;
    end else if (wr_take && avs_req_in.address == `OLMA_OFS_CTRL) begin
      ctrl_bits <= avs_req_in.writedata[`OLMA_CTRL_ARCH_BIT:`OLMA_CTRL_SYN_BIT];
    end else if (wr_take && avs_req_in.address == `OLMA_OFS_CELL) begin
      cell_pol <= avs_req_in.writedata[`OLMA_CELL_POL_LSB +: `OLMA_CELLS];
      cell_io_cfg <= avs_req_in.writedata[`OLMA_CELL_CFG_LSB +: `OLMA_CELLS];
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int c = 0; c < `OLMA_CELLS; c++) begin
        for (int t = 0; t < `OLMA_TERMS; t++) begin
          pt_mem[c][t] <= `OLMA_PT_RESET;
        end
      end
    end else if (wr_take && pt_hit) begin
      pt_mem[avs_req_in.address[`OLMA_PT_CELL_MSB:`OLMA_PT_CELL_LSB]]
            [avs_req_in.address[`OLMA_PT_TERM_MSB:`OLMA_PT_TERM_LSB]] <= avs_req_in.writedata;
    end
  end

  a_mode_decode: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (mode_code == REGISTERED_CODE) |-> (mode == OLMA_REGISTERED))
    else $error("registered code did not select registered mode");

  a_cell_cfg_write: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (wr_take && avs_req_in.address == `OLMA_OFS_CELL) |=>
      ({cell_io_cfg, cell_pol} == $past(avs_req_in.writedata[15:0])))
    else $error("cell configuration write not stored");

  a_reg_no_data: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (mode == OLMA_REGISTERED) |-> (sig[1:0] == 2'b00))
    else $error("special pins reached the array in registered mode");

  a_complex_outer_fb: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (mode == OLMA_COMPLEX) |-> (sig[`OLMA_FB_BASE + `OLMA_OUTER_LO] == pin_sync.special[`OLMA_SP_CLK]
      && sig[`OLMA_FB_BASE + `OLMA_OUTER_HI] == pin_sync.special[`OLMA_SP_OE]))
    else $error("special pins not on outer feedback in complex mode");

  a_simple_inner_out: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (mode == OLMA_SIMPLE) |=> (io_oe_n_out[`OLMA_INNER_HI:`OLMA_INNER_LO] == 2'b00))
    else $error("inner cells not driving in simple mode");

  a_reg_hold_q: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    !clk_rise |=> $stable(reg_q))
    else $error("register changed without a clock pin edge");

  a_reg_capture: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (mode == OLMA_REGISTERED && clk_rise) |=>
      ((reg_q & ~$past(cell_io_cfg)) == ($past(sum_all) & ~$past(cell_io_cfg))))
    else $error("registered cell did not capture its eight-term sum");

  a_reg_oe_off: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (mode == OLMA_REGISTERED && pin_sync.special[`OLMA_SP_OE]) |=>
      ((io_oe_n_out | $past(cell_io_cfg)) == 8'hFF))
    else $error("registered output driven while enable pin high");

  a_reg_polarity: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (mode == OLMA_REGISTERED) |=>
      ((io_data_out & ~$past(cell_io_cfg)) == (($past(reg_q) ^ $past(cell_pol)) & ~$past(cell_io_cfg))))
    else $error("registered output polarity wrong");

  a_complex_oe_term: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (mode == OLMA_COMPLEX) |=> (io_oe_n_out == ~$past(oe_term)))
    else $error("complex enable does not follow its product term");

endmodule

// File: sim/olma_board.sv
// Board-side model: drives the input pins and reads the cell pins back.
module olma_board
  import olma_pkg::*;
(
  input wire logic [1:0] special_in,
  input wire logic [5:0] ded_in,
  input wire logic [7:0] io_data_in,
  input wire logic [7:0] io_oe_n_in,
  output olma_pkg::olma_pins_t pins_out
);
  // A released cell pin floats up to the pull-up level instead of keeping the last driven value.
  always_comb begin
    pins_out.special = special_in;
    pins_out.ded = ded_in;
    for (int i = 0; i < 8; i++) begin
      pins_out.io[i] = io_oe_n_in[i] ? 1'b1 : io_data_in[i];
    end
  end
endmodule

// File: sim/tb.sv
// Self-checking bench for the output macrocell array.
`include "olma_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import olma_pkg::*;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  olma_bus_req_t req = '0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  olma_pins_t pins;
  logic [7:0] io_data_out;
  logic [7:0] io_oe_n_out;
  logic [1:0] special = 2'h0;
  logic [5:0] ded = 6'h00;
  logic [31:0] q;
  logic [7:0] pol;
  int mismatches = 0;
  int total_checks = 0;

  always #10 sys_clk_in = ~sys_clk_in;

  olma_top u_olma_top(.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .avs_req_in(req),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .pins_in(pins),
    .io_data_out(io_data_out), .io_oe_n_out(io_oe_n_out));
  olma_board u_olma_board(.special_in(special), .ded_in(ded), .io_data_in(io_data_out),
    .io_oe_n_in(io_oe_n_out), .pins_out(pins));

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // The request is held until waitrequest is seen low at a rising edge; no fixed latency is assumed.
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    req <= '{read: !wr, write: wr, address: a, writedata: d};
    @(posedge sys_clk_in);
    while (avs_waitrequest_out !== 1'b0 && n < 50) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n >= 50) begin
      mismatches++;
      $display("[FAIL] %0t bus access never answered", $time);
      end_sim;
    end
    q = avs_readdata_out;
    req <= '0;
  endtask

  // Pin changes pass a two-stage synchroniser and an output flop before they show.
  task automatic settle;
    repeat (5) @(posedge sys_clk_in);
  endtask

  function automatic logic [9:0] pt(input int c, input int t);
    return {`OLMA_PT_REGION, c[2:0], t[2:0], 2'b00};
  endfunction

  // Only cell 3 has a live term (dedicated input 0); every other sum stays false.
  function automatic logic [7:0] exp_simple(input logic [5:0] d, input logic [7:0] p);
    return p ^ {4'h0, d[0], 3'h0};
  endfunction

  initial begin
    #1000000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end

  initial begin
    void'($urandom(32'hFCC4E8E4));
    repeat (20) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    settle;
    chk(io_oe_n_out, 8'h00, "oe after reset");
    chk(io_data_out, 8'h00, "data after reset");
    bus(0, `OLMA_OFS_CTRL, 32'h0);
    chk(q, 32'h1, "ctrl reset value");
    bus(0, 10'h00C, 32'h0);
    chk(q, 32'h0, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      bus(1, `OLMA_OFS_CTRL, i);
      bus(0, `OLMA_OFS_STAT, 32'h0);
      chk(q[17:16], i[1:0], "global bits");
    end
    bus(1, `OLMA_OFS_CTRL, `OLMA_CODE_SIMPLE);
    bus(1, pt(3, 0), 32'h10);
    repeat (8) begin
      pol = 8'($urandom);
      @(posedge sys_clk_in);
      ded <= 6'($urandom);
      bus(1, `OLMA_OFS_CELL, {24'h0, pol});
      settle;
      chk(io_data_out, exp_simple(ded, pol), "simple sum");
      chk(io_oe_n_out, 8'h00, "simple always on");
    end
    bus(1, `OLMA_OFS_CELL, 32'hFF00);
    settle;
    chk(io_oe_n_out, 8'hE7, "inner cells stay outputs");
    @(posedge sys_clk_in);
    ded <= 6'h00;
    bus(1, `OLMA_OFS_CELL, 32'h0);
    bus(1, `OLMA_OFS_CTRL, `OLMA_CODE_COMPLEX);
    bus(1, pt(1, 0), 32'h0);
    bus(1, pt(2, 0), 32'h0);
    bus(1, pt(2, 1), 32'h10000);
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk_in);
      special <= {1'b0, s[0]};
      settle;
      chk(io_oe_n_out, 8'hF9, "complex enable term");
      chk(io_data_out, {5'h0, s[0], 2'h0}, "special pin on outer slot");
    end
    @(posedge sys_clk_in);
    special <= 2'b00;
    ded <= 6'h02;
    bus(1, pt(0, 0), 32'h40);
    bus(1, `OLMA_OFS_CTRL, `OLMA_CODE_REGISTERED);
    settle;
    @(posedge sys_clk_in);
    special[0] <= 1'b1;
    settle;
    chk(io_data_out, 8'h07, "registered capture");
    chk(io_oe_n_out, 8'h00, "shared enable on");
    @(posedge sys_clk_in);
    ded <= 6'h00;
    special <= 2'b11;
    settle;
    chk(io_oe_n_out, 8'hFF, "shared enable off");
    bus(0, `OLMA_OFS_STAT, 32'h0);
    chk(q[7:0], 8'h07, "register kept without clock");
    bus(1, `OLMA_OFS_CELL, 32'h2000);
    bus(1, pt(5, 0), 32'h0);
    settle;
    chk(io_oe_n_out, 8'hDF, "registered cell as I/O");
    end_sim;
  end
endmodule
